// >>> design/cssq_defines.svh
// Constants for the converter start sequencer
// How it works
// - Mode picks lockout, pin, command or AND gating
// - Gate true waits turn-on delay, then regulates
// - Gate false regulates through turn-off delay, stops
// - Delays count whole soft-start periods
// - Power good released only when output in window
// - Command bit 7 powers on; bits 5:4 select margin
// - No pulses until soft-start exceeds feedback
// - Low-side on-time grows over first 128 pulses
// - After 128 pulses low side fully complementary
// - Over-voltage acted on in every state
// - Reference ramps from zero at rise-time slew
// - Margin none, high or low offsets reference
`ifndef CSSQ_DEFINES_SVH
`define CSSQ_DEFINES_SVH

// ****************************************
// Time base
// ****************************************
`define CSSQ_CLK_NS 10
`define CSSQ_TICK_NS 1000
`define CSSQ_TICK_CYCLES (`CSSQ_TICK_NS / `CSSQ_CLK_NS)
`define CSSQ_DIV_W 7
`define CSSQ_RISE_MIN_US 12'h006

// ****************************************
// Operation command and reference
// ****************************************
`define CSSQ_OP_ON_BIT 7
`define CSSQ_OP_MARGIN_LSB 4
`define CSSQ_VREF_NOM_MV 12'sh258
`define CSSQ_VREF_MAX_MV 12'sh3ff
`define CSSQ_PREBIAS_PULSES 8'h80

`endif

// >>> design/cssq_pkg.sv
// Types for the converter start sequencer
`default_nettype none
package cssq_pkg;
  typedef enum logic [1:0] {
    CSSQ_GATE_VIN  = 2'b00,
    CSSQ_GATE_PIN  = 2'b01,
    CSSQ_GATE_CMD  = 2'b10,
    CSSQ_GATE_BOTH = 2'b11
  } cssq_gate_e;

  typedef enum logic [1:0] {
    CSSQ_MRG_NONE = 2'b00,
    CSSQ_MRG_LOW  = 2'b01,
    CSSQ_MRG_HIGH = 2'b10,
    CSSQ_MRG_RSVD = 2'b11
  } cssq_margin_e;

  typedef enum logic [2:0] {
    CSSQ_OFF      = 3'b000,
    CSSQ_TON_WAIT = 3'b001,
    CSSQ_SOFT     = 3'b010,
    CSSQ_REG      = 3'b011,
    CSSQ_TOFF     = 3'b100
  } cssq_state_e;

  typedef struct packed {
    logic [9:0] ref_mv;
    logic [20:0] acc;
  } cssq_ramp_s;

  typedef struct packed {
    cssq_state_e st;
    logic [6:0] div;
    logic [11:0] tick_cnt;
    logic [3:0] per_cnt;
    logic gate;
    logic ss_done;
    logic [9:0] target;
    logic sw_en;
    logic [7:0] pulse_cnt;
    logic compl;
    logic pg;
    logic ov;
    logic regulating;
  } cssq_top_s;
endpackage
`default_nettype wire

// >>> design/cssq_ref_ramp.sv
// Reference ramp: slews the internal reference toward its target
`default_nettype none
`include "cssq_defines.svh"
module cssq_ref_ramp
  import cssq_pkg::*;
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Control
  input wire logic clear_i,
  input wire logic run_i,
  input wire logic [9:0] target_i,
  input wire logic [19:0] ss_cycles_i,
  // Result
  output logic [9:0] ref_o,
  output logic at_target_o
);
  cssq_ramp_s s_q, s_d;
  logic [20:0] acc_sum;

  // Bresenham stepping: 600 mV over ss_cycles, at most one code per cycle
  always_comb begin
    s_d = s_q;
    acc_sum = s_q.acc + 21'(`CSSQ_VREF_NOM_MV);
    if (clear_i) begin
      s_d.ref_mv = 10'h000;
      s_d.acc = 21'h00000;
    end else if (run_i && (s_q.ref_mv != target_i)) begin
      if (acc_sum >= {1'b0, ss_cycles_i}) begin
        s_d.acc = acc_sum - {1'b0, ss_cycles_i};
        if (s_q.ref_mv < target_i) begin
          s_d.ref_mv = s_q.ref_mv + 10'h001;
        end else begin
          s_d.ref_mv = s_q.ref_mv - 10'h001;
        end
      end else begin
        s_d.acc = acc_sum;
      end
    end else begin
      s_d.acc = 21'h00000;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign ref_o = s_q.ref_mv;
  assign at_target_o = (s_q.ref_mv == target_i);
endmodule
`default_nettype wire

// >>> design/cssq_sequencer.sv
// Converter start sequencer: gating, delays, soft-start, pre-bias, power good
`default_nettype none
`include "cssq_defines.svh"
module cssq_sequencer
  import cssq_pkg::*;
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic reset_n_i,
  // Start gating
  input wire logic [1:0] on_off_mode_i,
  input wire logic vin_above_lockout_i,
  input wire logic control_input_pin_i,
  input wire logic [7:0] operation_cmd_i,
  // Timing configuration
  input wire logic [3:0] ton_delay_i,
  input wire logic [3:0] toff_delay_i,
  input wire logic [11:0] ton_rise_us_i,
  // Reference offsets in mV, two's complement
  input wire logic [7:0] vref_trim_i,
  input wire logic [7:0] margin_high_step_i,
  input wire logic [7:0] margin_low_step_i,
  // Analog monitors
  input wire logic [9:0] feedback_input_i,
  input wire logic fb_in_window_i,
  input wire logic fb_overvoltage_i,
  input wire logic switch_node_pulse_i,
  // Status and control outputs
  output logic regulating_o,
  output logic [9:0] reference_o,
  output logic switching_enable_o,
  output logic [7:0] low_side_ontime_o,
  output logic low_side_complementary_o,
  output logic ov_protect_o,
  // Open-drain power good
  output logic power_good_output_o,
  output logic power_good_output_oe_o
);
  logic rst_meta_q, rst_sync_q;
  cssq_top_s s_q, s_d;
  logic tick, gate_now, gate_changed, delay_done, ramp_clear, ramp_run, at_target;
  logic [3:0] cur_delay;
  logic [11:0] rise_us;
  logic [19:0] ss_cycles;
  logic signed [11:0] tgt_sum;
  logic [9:0] ramp_ref;

  // ****************************************
  // Reset release
  // ****************************************
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // ****************************************
  // Helpers
  // ****************************************
  // Every mode still needs the input above lockout
  function automatic logic gate_of(input logic [1:0] mode, input logic vin, input logic pin,
                                   input logic [7:0] cmd);
    logic on;
    on = cmd[`CSSQ_OP_ON_BIT];
    case (cssq_gate_e'(mode))
      CSSQ_GATE_VIN: gate_of = vin;
      CSSQ_GATE_PIN: gate_of = vin & pin;
      CSSQ_GATE_CMD: gate_of = vin & on;
      default: gate_of = vin & pin & on;
    endcase
  endfunction

  function automatic logic signed [11:0] sext(input logic [7:0] v);
    sext = {{4{v[7]}}, v};
  endfunction

  // ****************************************
  // Derived values
  // ****************************************
  // Rise time floor keeps the ramp at no more than one code per cycle
  assign rise_us = (ton_rise_us_i < `CSSQ_RISE_MIN_US) ? `CSSQ_RISE_MIN_US : ton_rise_us_i;
  assign ss_cycles = 20'(rise_us * `CSSQ_TICK_CYCLES);
  assign gate_now = gate_of(on_off_mode_i, vin_above_lockout_i, control_input_pin_i, operation_cmd_i);
  assign gate_changed = gate_now != s_q.gate;
  assign cur_delay = (s_q.st == CSSQ_TON_WAIT) ? ton_delay_i : toff_delay_i;
  assign delay_done = (s_q.per_cnt >= cur_delay);
  assign tick = (s_q.div == 7'(`CSSQ_TICK_CYCLES - 1));
  assign ramp_clear = (s_q.st == CSSQ_OFF) || (s_q.st == CSSQ_TON_WAIT);
  assign ramp_run = !ramp_clear;

  always_comb begin
    tgt_sum = `CSSQ_VREF_NOM_MV + sext(vref_trim_i);
    case (cssq_margin_e'(operation_cmd_i[`CSSQ_OP_MARGIN_LSB +: 2]))
      CSSQ_MRG_HIGH: tgt_sum = tgt_sum + sext(margin_high_step_i);
      CSSQ_MRG_LOW: tgt_sum = tgt_sum + sext(margin_low_step_i);
      default: tgt_sum = tgt_sum;
    endcase
  end

  // ****************************************
  // Reference ramp
  // ****************************************
  cssq_ref_ramp u_ramp (
    .mclk_i(mclk_i),
    .rst_n_i(rst_sync_q),
    .clear_i(ramp_clear),
    .run_i(ramp_run),
    .target_i(s_q.target),
    .ss_cycles_i(ss_cycles),
    .ref_o(ramp_ref),
    .at_target_o(at_target)
  );

  // ****************************************
  // Sequencer
  // ****************************************
  always_comb begin
    s_d = s_q;
    s_d.gate = gate_now;
    s_d.div = tick ? 7'h00 : s_q.div + 7'h01;
    if (tgt_sum < 12'sh000) begin
      s_d.target = 10'h000;
    end else if (tgt_sum > `CSSQ_VREF_MAX_MV) begin
      s_d.target = 10'h3ff;
    end else begin
      s_d.target = tgt_sum[9:0];
    end
    // Delay counting in whole soft-start periods of 1 us ticks
    // Prescaler restarts too, else a free-running phase shortens the first period
    if (gate_changed) begin
      s_d.div = 7'h00;
      s_d.tick_cnt = 12'h000;
      s_d.per_cnt = 4'h0;
    end else if (tick && !delay_done) begin
      if (s_q.tick_cnt == rise_us - 12'h001) begin
        s_d.tick_cnt = 12'h000;
        s_d.per_cnt = s_q.per_cnt + 4'h1;
      end else begin
        s_d.tick_cnt = s_q.tick_cnt + 12'h001;
      end
    end
    case (s_q.st)
      CSSQ_OFF: begin
        s_d.ss_done = 1'b0;
        if (gate_now) begin
          s_d.st = CSSQ_TON_WAIT;
        end
      end
      CSSQ_TON_WAIT: begin
        if (!gate_now) begin
          s_d.st = CSSQ_OFF;
        end else if (!gate_changed && delay_done) begin
          s_d.st = CSSQ_SOFT;
        end
      end
      CSSQ_SOFT: begin
        if (!gate_now) begin
          s_d.st = CSSQ_TOFF;
        end else if (at_target) begin
          s_d.ss_done = 1'b1;
          s_d.st = CSSQ_REG;
        end
      end
      CSSQ_REG: begin
        if (!gate_now) begin
          s_d.st = CSSQ_TOFF;
        end
      end
      CSSQ_TOFF: begin
        if (gate_now) begin
          s_d.st = s_q.ss_done ? CSSQ_REG : CSSQ_SOFT;
        end else if (!gate_changed && delay_done) begin
          s_d.st = CSSQ_OFF;
        end
      end
      default: begin
        s_d.st = CSSQ_OFF;
      end
    endcase
    s_d.regulating = (s_d.st == CSSQ_SOFT) || (s_d.st == CSSQ_REG) || (s_d.st == CSSQ_TOFF);
    // Over-voltage is watched in every state, also off or below lockout
    s_d.ov = fb_overvoltage_i;
    // Pre-bias: hold pulses until the ramp passes the feedback level
    if (!s_q.regulating || fb_overvoltage_i) begin
      s_d.sw_en = 1'b0;
    end else if (ramp_ref > feedback_input_i) begin
      s_d.sw_en = 1'b1;
    end
    if (!s_q.regulating) begin
      s_d.pulse_cnt = 8'h00;
      s_d.compl = 1'b0;
    end else if (s_q.sw_en && switch_node_pulse_i && !s_q.compl) begin
      s_d.pulse_cnt = s_q.pulse_cnt + 8'h01;
      s_d.compl = (s_q.pulse_cnt == `CSSQ_PREBIAS_PULSES - 8'h01);
    end
    // Window held after start-up; any excursion drops it again
    s_d.pg = s_q.ss_done && ((s_q.st == CSSQ_REG) || (s_q.st == CSSQ_TOFF)) &&
             fb_in_window_i && !fb_overvoltage_i;
  end

  always_ff @(posedge mclk_i or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign regulating_o = s_q.regulating;
  assign reference_o = ramp_ref;
  assign switching_enable_o = s_q.sw_en;
  assign low_side_ontime_o = s_q.pulse_cnt;
  assign low_side_complementary_o = s_q.compl;
  assign ov_protect_o = s_q.ov;
  // Pin is only ever pulled low; released means enable off
  assign power_good_output_o = 1'b0;
  assign power_good_output_oe_o = !s_q.pg;
endmodule
`default_nettype wire

// >>> dv/cssq_host_model.sv
// Host and upstream device driving the start controls
`default_nettype none
module cssq_host_model (
  // Clock
  input wire logic mclk_i,
  // Controls toward the sequencer
  output logic [7:0] op_cmd_o,
  output logic pin_o
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    op_cmd_o = 8'h00;
    pin_o = 1'b0;
  end
  // Unused command bits stay zero so only on and margin move
  task automatic drive(input logic pin, input logic on, input logic [1:0] mrg);
    @(posedge mclk_i);
    #1;
    op_cmd_o = {on, 1'h0, mrg, 4'h0};
    pin_o = pin;
  endtask
endmodule
`default_nettype wire

// >>> dv/cssq_sequencer_chk.sv
// Assertion checker for the converter start sequencer
`default_nettype none
module cssq_sequencer_chk (
  // Clock, reset and gating
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic [1:0] on_off_mode_i,
  input wire logic vin_above_lockout_i,
  input wire logic control_input_pin_i,
  input wire logic [7:0] operation_cmd_i,
  input wire logic [3:0] toff_delay_i,
  // Monitors
  input wire logic [9:0] feedback_input_i,
  input wire logic fb_in_window_i,
  input wire logic fb_overvoltage_i,
  // Outputs
  input wire logic regulating_o,
  input wire logic [9:0] reference_o,
  input wire logic switching_enable_o,
  input wire logic [7:0] low_side_ontime_o,
  input wire logic low_side_complementary_o,
  input wire logic ov_protect_o,
  input wire logic power_good_output_o,
  input wire logic power_good_output_oe_o
);
  // Internal reset trails the pin by two edges, so wait three
  logic [1:0] up_q;
  logic gate;
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) up_q <= 2'h0;
    else if (up_q != 2'h3) up_q <= up_q + 2'h1;
  end
  assign gate = vin_above_lockout_i & (!on_off_mode_i[0] | control_input_pin_i)
    & (!on_off_mode_i[1] | operation_cmd_i[7]);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (up_q != 2'h3);
  // ****************************************
  // Properties
  // ****************************************
  property p_ton; $rose(regulating_o) |-> $past(gate) && $past(gate, 2); endproperty
  a_ton: assert property (p_ton) else $error("start without gate");
  property p_toff; $fell(gate) && regulating_o && toff_delay_i != 4'h0 |=> regulating_o [*8]; endproperty
  a_toff: assert property (p_toff) else $error("early stop");
  property p_pgr; $fell(power_good_output_oe_o) |-> $past(fb_in_window_i) && regulating_o; endproperty
  a_pgr: assert property (p_pgr) else $error("pg out of window");
  property p_pgd; power_good_output_o == 1'b0; endproperty
  a_pgd: assert property (p_pgd) else $error("pg drives high");
  property p_sw; $rose(switching_enable_o) |-> $past(reference_o > feedback_input_i) && regulating_o; endproperty
  a_sw: assert property (p_sw) else $error("early pulses");
  property p_cnt; $changed(low_side_ontime_o) |-> low_side_ontime_o == $past(low_side_ontime_o) + 8'h01
    || low_side_ontime_o == 8'h00; endproperty
  a_cnt: assert property (p_cnt) else $error("on-time jump");
  property p_cmp; $rose(low_side_complementary_o) |-> low_side_ontime_o == 8'h80; endproperty
  a_cmp: assert property (p_cmp) else $error("early complementary");
  property p_ov; fb_overvoltage_i |=> ov_protect_o; endproperty
  a_ov: assert property (p_ov) else $error("ov ignored");
  property p_ref; $changed(reference_o) |-> reference_o == $past(reference_o) + 10'h001
    || reference_o + 10'h001 == $past(reference_o) || reference_o == 10'h000; endproperty
  a_ref: assert property (p_ref) else $error("reference jump");
  c_cmp: cover property ($rose(low_side_complementary_o));
  c_pg: cover property ($fell(power_good_output_oe_o));
  c_off: cover property ($fell(regulating_o));
endmodule
bind cssq_sequencer cssq_sequencer_chk u_chk (.mclk_i, .reset_n_i, .on_off_mode_i, .vin_above_lockout_i,
  .control_input_pin_i, .operation_cmd_i, .toff_delay_i, .feedback_input_i, .fb_in_window_i, .fb_overvoltage_i,
  .regulating_o, .reference_o, .switching_enable_o, .low_side_ontime_o, .low_side_complementary_o,
  .ov_protect_o, .power_good_output_o, .power_good_output_oe_o);
`default_nettype wire

// >>> dv/testbench.sv
// Self-checking bench for the converter start sequencer
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [1:0] on_off_mode_i = 2'h0;
  logic vin_above_lockout_i = 1'b0;
  logic control_input_pin_i;
  logic [7:0] operation_cmd_i;
  logic [3:0] ton_delay_i = 4'h0, toff_delay_i = 4'h0;
  logic [11:0] ton_rise_us_i = 12'h002;
  logic [7:0] vref_trim_i = 8'hfc, margin_high_step_i = 8'h14, margin_low_step_i = 8'hec;
  logic [9:0] feedback_input_i = 10'h000, reference_o;
  logic fb_in_window_i = 1'b0, fb_overvoltage_i = 1'b0, switch_node_pulse_i = 1'b0;
  logic regulating_o, switching_enable_o, low_side_complementary_o, ov_protect_o;
  logic power_good_output_o, power_good_output_oe_o;
  logic [7:0] low_side_ontime_o;
  int failures = 0, tests_run = 0, e;
  always #5 mclk_i = ~mclk_i;
  cssq_host_model u_cssq_host_model (.mclk_i, .op_cmd_o(operation_cmd_i), .pin_o(control_input_pin_i));
  cssq_sequencer u_cssq_sequencer (.mclk_i, .reset_n_i, .on_off_mode_i, .vin_above_lockout_i,
    .control_input_pin_i, .operation_cmd_i, .ton_delay_i, .toff_delay_i, .ton_rise_us_i, .vref_trim_i,
    .margin_high_step_i, .margin_low_step_i, .feedback_input_i, .fb_in_window_i, .fb_overvoltage_i,
    .switch_node_pulse_i, .regulating_o, .reference_o, .switching_enable_o, .low_side_ontime_o,
    .low_side_complementary_o, .ov_protect_o, .power_good_output_o, .power_good_output_oe_o);
  // ****************************************
  // Tasks
  // ****************************************
  task automatic step(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic flg(input logic got, input logic exp);
    chk({9'h000, got}, {9'h000, exp});
  endtask
  task automatic pulse(input int n);
    repeat (n) begin
      switch_node_pulse_i = 1'b1;
      step(1);
      switch_node_pulse_i = 1'b0;
      step(1);
    end
  endtask
  task automatic print_verdict;
    $display("failures %0d tests_run %0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    step(10000);
    failures++;
    print_verdict;
  end
  initial begin
    step(3);
    reset_n_i = 1'b1;
    step(3);
    flg(power_good_output_oe_o, 1'b1);
    flg(power_good_output_o, 1'b0);
    chk(reference_o, 10'h000);
    fb_overvoltage_i = 1'b1;
    step(2);
    flg(ov_protect_o, 1'b1);
    fb_overvoltage_i = 1'b0;
    // Every mode against every pin and command level
    for (int i = 0; i < 16; i++) begin
      on_off_mode_i = i[3:2];
      u_cssq_host_model.drive(i[1], i[0], 2'h0);
      vin_above_lockout_i = 1'b1;
      step(10);
      flg(regulating_o, (!i[2] | i[1]) & (!i[3] | i[0]));
      vin_above_lockout_i = 1'b0;
      step(10);
      flg(regulating_o, 1'b0);
    end
    // Rise below the floor counts as 600 cycles; a glitch restarts the wait
    ton_delay_i = 4'h1;
    toff_delay_i = 4'h2;
    feedback_input_i = 10'h12c;
    vin_above_lockout_i = 1'b1;
    step(300);
    vin_above_lockout_i = 1'b0;
    step(5);
    vin_above_lockout_i = 1'b1;
    step(590);
    flg(regulating_o, 1'b0);
    step(20);
    flg(regulating_o, 1'b1);
    step(250);
    flg(switching_enable_o, 1'b0);
    step(100);
    flg(switching_enable_o, 1'b1);
    pulse(127);
    chk({2'h0, low_side_ontime_o}, 10'h07f);
    flg(low_side_complementary_o, 1'b0);
    pulse(1);
    chk({2'h0, low_side_ontime_o}, 10'h080);
    flg(low_side_complementary_o, 1'b1);
    flg(power_good_output_oe_o, 1'b1);
    fb_in_window_i = 1'b1;
    for (int m = 0; m < 4; m++) begin
      u_cssq_host_model.drive(1'b1, 1'b1, m[1:0]);
      step(60);
      e = 600 + $signed(vref_trim_i);
      e = e + (m == 1 ? $signed(margin_low_step_i) : m == 2 ? $signed(margin_high_step_i) : 0);
      chk(reference_o, e[9:0]);
    end
    flg(power_good_output_oe_o, 1'b0);
    fb_overvoltage_i = 1'b1;
    step(3);
    flg(ov_protect_o, 1'b1);
    flg(power_good_output_oe_o, 1'b1);
    fb_overvoltage_i = 1'b0;
    u_cssq_host_model.drive(1'b1, 1'b0, 2'h0);
    step(1190);
    flg(regulating_o, 1'b1);
    step(20);
    flg(regulating_o, 1'b0);
    flg(ov_protect_o, 1'b0);
    print_verdict;
  end
endmodule
`default_nettype wire
